// >>> common/pum_pkg.sv
package pum_pkg;

  // Number of host cores sharing one wake pin.
  localparam int NCORE = 3;
  // APB address width and data width.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets within one core window.
  localparam logic [7:0] OFS_PMCSR = 8'h00;
  localparam logic [7:0] OFS_PMC = 8'h04;
  localparam logic [7:0] OFS_USB = 8'h08;
  // Spacing of the per-core windows.
  localparam logic [7:0] CORE_STRIDE = 8'h10;
  // Global registers after the core windows.
  localparam logic [7:0] OFS_GCTRL = 8'h30;
  localparam logic [7:0] OFS_GSTAT = 8'h34;

  // Field positions.
  localparam int PS_LSB = 0;
  localparam int WEN_BIT = 8;
  localparam int WST_BIT = 15;
  localparam int AUX_LSB = 6;
  localparam int SUP_LSB = 11;
  localparam int USB_LSB = 0;
  localparam int USBEFF_LSB = 2;
  localparam int IDOVR_BIT = 0;
  localparam int BUSERR_BIT = 0;
  localparam int BUS_LSB = 4;
  localparam int CRST_BIT = 8;
  localparam int SUP_W = 5;
  localparam int AUX_W = 3;
  // Index of the D3cold bit in the supported wake field.
  localparam int SUP_COLD_IDX = 4;

  // Function power states as held in the power state field.
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3 = 2'h3;
  // Bus power states as reported on the bus state pins.
  localparam logic [1:0] BUS_B0 = 2'h0;
  localparam logic [1:0] BUS_B1 = 2'h1;
  localparam logic [1:0] BUS_B2 = 2'h2;
  localparam logic [1:0] BUS_B3 = 2'h3;

  // Reset values: no wake support in D3cold, no aux current.
  localparam logic [4:0] SUP_RST = 5'h0F;
  localparam logic [2:0] AUX_RST = 3'h0;

  // Clock rates.
  localparam int PCLK_MHZ = 200;
  localparam int PCI_CLK_MHZ = 33;

  // USB bus states: stopped, active, constant J, driven K.
  typedef enum logic [1:0] {
    pum_usb_reset,
    pum_usb_oper,
    pum_usb_susp,
    pum_usb_resume
  } pum_usb_t;

  // State of one core's power-management slice.
  typedef struct packed {
    logic [1:0] pstate;
    logic wake_en;
    logic wake_st;
    logic [4:0] sup;
    logic [2:0] aux;
    pum_usb_t usb_req;
  } pum_core_st_t;

endpackage

// >>> dv/pum_host_model.sv
`timescale 1ns/1ps
// Host bridge and system power logic that drive the power pins.
module pum_host_model #(
  parameter int LAG = 6
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Sleep request and the bus state wanted while awake.
  input wire logic sleep,
  input wire logic [1:0] bus_req,
  // Pins towards the device.
  output logic pwr_rel,
  output logic [1:0] bus_st
);
  // Spacing counter between pin and bus moves.
  int cnt;

  // Entry blocks accesses before power goes; exit powers the bus first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_rel <= 1'b1;
      bus_st <= pum_pkg::BUS_B0;
      cnt <= 0;
    end else if (sleep) begin
      pwr_rel <= 1'b0;
      cnt <= (cnt < LAG) ? cnt + 1 : cnt;
      if (cnt == LAG) begin
        bus_st <= pum_pkg::BUS_B3;
      end
    end else if (!pwr_rel) begin
      // The bus reset is over before the pin rises again.
      bus_st <= pum_pkg::BUS_B0;
      cnt <= cnt - 1;
      if (cnt == 0) begin
        pwr_rel <= 1'b1;
      end
    end else begin
      bus_st <= bus_req;
      cnt <= 0;
    end
  end
endmodule

// >>> dv/pum_top_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the power-management block.
module pum_top_bench;
  // Bus and pin drives, all given a value at time zero.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] wake = 3'h0;
  logic rom_v = 1'b0;
  logic [4:0] rom_s = 5'h00;
  logic [2:0] rom_a = 3'h0;
  logic sleep = 1'b0;
  logic [1:0] bus_req = 2'h0;
  // Design outputs and model pins.
  logic [31:0] prdata;
  logic pready, pslverr, wev, bus_en, txn, wonly, pwr;
  logic [1:0] bus;
  logic [5:0] usb_st;
  // Last read result and the random state.
  logic [31:0] rd;
  logic er;
  logic [15:0] lfsr = 16'h97A7;
  int err_count = 0;
  int num_checks = 0;

  // Free-running clock of 5 ns.
  always #2.5 pclk = ~pclk;

  pum_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_power_reset_in(pwr), .pci_bus_state_in(bus),
    .usb_wake_in(wake), .rom_load_valid(rom_v), .rom_sup(rom_s),
    .rom_aux(rom_a), .wake_event_out(wev), .pci_bus_enable(bus_en),
    .pci_txn_allow(txn), .pci_wake_only(wonly), .usb_state_out(usb_st));
  pum_host_model #(.LAG(6)) host_u (.clk(pclk), .rst_n(presetn),
    .sleep(sleep), .bus_req(bus_req), .pwr_rel(pwr), .bus_st(bus));

  // Next random word.
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Capability word with the support field and the aux current field.
  function automatic logic [31:0] pmc_exp(input logic [4:0] s,
    input logic [2:0] a);
    return {16'h0000, s, 2'h0, a, 6'h00};
  endfunction
  // Active and resume codes are odd; outside D0 they fall to suspend.
  function automatic logic [1:0] usb_exp(input logic [1:0] r,
    input logic d0);
    return (!d0 && r[0]) ? 2'h2 : r;
  endfunction

  // Compares with case equality so an unknown never matches.
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One transfer; the request holds until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Reads a register and expects a clean answer.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({er, rd}, {1'b0, e});
  endtask
  // Same word to every core.
  task automatic wr3(input logic [7:0] o, input logic [31:0] d);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'(16 * i) + o, d);
    end
  endtask
  // A wake detection on one core pin, then time to reach the output.
  task automatic pulse(input int i);
    wake[i] <= 1'b1;
    repeat (3) @(posedge pclk);
    wake[i] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  // Enters or leaves the sleep state through the host model.
  task automatic nap(input logic s);
    sleep <= s;
    repeat (16) @(posedge pclk);
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs about 600 cycles.
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    tally_and_finish;
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      rdc(8'(16 * i), 32'h0);
      rdc(8'(16 * i + 4), pmc_exp(5'h0F, 3'h0));
    end
    apb(1'b0, 8'h0C, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    // Every requested bus code in every power state.
    for (int p = 0; p < 4; p++) begin
      wr3(8'h00, 32'(p));
      for (int r = 0; r < 4; r++) begin
        wr3(8'h08, 32'(r));
        repeat (2) @(posedge pclk);
        chk(33'(usb_st), 33'({3{usb_exp(2'(r), p == 0)}}));
      end
    end
    wr3(8'h00, 32'h0);
    // Wake flag on each core, enabled first, then cleared.
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'(16 * i), 32'h100);
      pulse(i);
      chk(33'(wev), 33'h1);
      rdc(8'(16 * i), 32'h8100);
      apb(1'b1, 8'(16 * i), 32'h8000);
      repeat (3) @(posedge pclk);
      chk(33'(wev), 33'h0);
    end
    // A flag that is set while disabled shows once enabled.
    lfsr = step(lfsr);
    pulse(lfsr % 3);
    chk(33'(wev), 33'h0);
    wr3(8'h00, 32'h100);
    repeat (3) @(posedge pclk);
    chk(33'(wev), 33'h1);
    wr3(8'h00, 32'h8000);
    // Bus states B0 to B2 as the host requests them.
    for (int b = 0; b < 3; b++) begin
      bus_req <= 2'(b);
      repeat (6) @(posedge pclk);
      chk(33'({txn, wonly, bus_en}), (b == 0) ? 33'h5 : 33'h3);
    end
    rdc(8'h34, 32'h121);
    bus_req <= 2'h0;
    // Capability writes refused without override, then taken.
    lfsr = step(lfsr);
    apb(1'b1, 8'h04, pmc_exp(lfsr[4:0], lfsr[7:5]));
    rdc(8'h04, pmc_exp(5'h0F, 3'h0));
    apb(1'b1, 8'h30, 32'h1);
    for (int i = 0; i < 3; i++) begin
      lfsr = step(lfsr);
      apb(1'b1, 8'(16 * i + 4), pmc_exp(lfsr[4:0], lfsr[7:5]));
      rdc(8'(16 * i + 4), pmc_exp(lfsr[4:0], lfsr[7:5]));
    end
    lfsr = step(lfsr);
    rom_s <= lfsr[4:0];
    rom_a <= lfsr[7:5];
    rom_v <= 1'b1;
    @(posedge pclk);
    rom_v <= 1'b0;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      rdc(8'(16 * i + 4), pmc_exp(lfsr[4:0], lfsr[7:5]));
    end
    // Cold state without cold wake support: the wake is dropped.
    wr3(8'h04, pmc_exp(5'h0F, 3'h0));
    wr3(8'h08, 32'h1);
    wr3(8'h00, 32'h103);
    nap(1'b1);
    chk(33'({txn, wonly, bus_en}), 33'h2);
    chk(33'(usb_st), 33'h2A);
    apb(1'b1, 8'h00, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    pulse(0);
    chk(33'(wev), 33'h0);
    nap(1'b0);
    rdc(8'h00, 32'h100);
    rdc(8'h30, 32'h1);
    // With cold support the wake comes out while the bus is off.
    wr3(8'h04, pmc_exp(5'h1F, 3'h7));
    wr3(8'h00, 32'h103);
    nap(1'b1);
    pulse(1);
    chk(33'(wev), 33'h1);
    nap(1'b0);
    rdc(8'h10, 32'h8100);
    // Power reset outside D3 clears every register.
    wr3(8'h00, 32'h8100);
    nap(1'b1);
    nap(1'b0);
    rdc(8'h30, 32'h0);
    rdc(8'h10, 32'h0);
    rdc(8'h14, pmc_exp(5'h0F, 3'h0));
    chk(33'(wev), 33'h0);
    tally_and_finish;
  end
endmodule

// >>> dv/pum_top_chk_sva.sv
`timescale 1ns/1ps
// Checks the gating and wake relations at the ports of the top module.
module pum_top_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus handshake.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins from the system.
  input wire logic core_power_reset_in,
  input wire logic [1:0] pci_bus_state_in,
  input wire logic [pum_pkg::NCORE-1:0] usb_wake_in,
  // Outputs under watch.
  input wire logic wake_event_out,
  input wire logic pci_bus_enable,
  input wire logic pci_txn_allow,
  input wire logic pci_wake_only
);
  // Goes high once any wake pin was seen, since the output needs a cause.
  logic seen_r;

  // Sticky record of wake activity; cleared only by the full reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 1'b0;
    end else if (|usb_wake_in) begin
      seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Four edges cover the two sync stages and the output register.
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready in the cycle after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  err_off_a: assert property (!core_power_reset_in [*4] ##0
    (psel && !penable) |=> pslverr)
    else $error("access not refused while power reset low");
  bus_off_a: assert property (!core_power_reset_in [*4]
    |-> !pci_bus_enable)
    else $error("bus signals enabled while power reset low");
  bus_on_a: assert property (core_power_reset_in [*4]
    |-> pci_bus_enable)
    else $error("bus signals disabled while power reset high");
  wake_only_a: assert property ((pci_bus_state_in != 2'h0) [*4]
    |-> pci_wake_only && !pci_txn_allow)
    else $error("transactions allowed outside B0");
  txn_ok_a: assert property ((pci_bus_state_in == 2'h0
    && core_power_reset_in) [*4] |-> pci_txn_allow && !pci_wake_only)
    else $error("transactions blocked in B0");
  wake_cause_a: assert property (wake_event_out |-> seen_r)
    else $error("wake output without any wake flag");
endmodule

bind pum_top pum_top_chk chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .core_power_reset_in(core_power_reset_in),
  .pci_bus_state_in(pci_bus_state_in), .usb_wake_in(usb_wake_in),
  .wake_event_out(wake_event_out), .pci_bus_enable(pci_bus_enable),
  .pci_txn_allow(pci_txn_allow), .pci_wake_only(pci_wake_only));

// >>> hw/pum_core_pm.sv
`timescale 1ns/1ps
// Power-management register slice of one host core.
module pum_core_pm (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Whole-slice clear and power-state-only return to D0.
  input wire logic clr,
  input wire logic d0_force,
  // Register writes, already qualified by the bus.
  input wire logic wr_pmcsr,
  input wire logic wr_pmc,
  input wire logic wr_usb,
  input wire logic [31:0] wdata,
  input wire logic id_ovr,
  // Capability load from the serial ROM loader.
  input wire logic rom_valid,
  input wire logic [4:0] rom_sup,
  input wire logic [2:0] rom_aux,
  // Wake event pulse and cold (bus unpowered) indication.
  input wire logic wake_evt,
  input wire logic cold,
  // Read views and derived state.
  output logic [31:0] pmcsr_rd,
  output logic [31:0] pmc_rd,
  output logic [31:0] usb_rd,
  output logic wake_req,
  output logic in_d3,
  output pum_pkg::pum_usb_t usb_eff
);

  pum_pkg::pum_core_st_t st_r;
  pum_pkg::pum_core_st_t st_nxt;
  // Index of the current state in the supported wake field.
  logic [2:0] sup_idx;

  // Next-state logic of the slice.
  always_comb begin
    st_nxt = st_r;
    sup_idx = cold ? 3'(pum_pkg::SUP_COLD_IDX) : {1'b0, st_r.pstate};
    if (wr_pmcsr) begin
      st_nxt.pstate = wdata[pum_pkg::PS_LSB +: 2];
      st_nxt.wake_en = wdata[pum_pkg::WEN_BIT];
      // Writing one clears the wake status.
      if (wdata[pum_pkg::WST_BIT]) begin
        st_nxt.wake_st = 1'b0;
      end
    end
    // Capabilities change only under the override, from the ROM or on a clear.
    if (wr_pmc && id_ovr) begin // (R10)
      st_nxt.sup = wdata[pum_pkg::SUP_LSB +: pum_pkg::SUP_W];
      st_nxt.aux = wdata[pum_pkg::AUX_LSB +: pum_pkg::AUX_W];
    end else if (rom_valid) begin // (R10)
      st_nxt.sup = rom_sup;
      st_nxt.aux = rom_aux;
    end
    if (wr_usb) begin
      st_nxt.usb_req = pum_pkg::pum_usb_t'(wdata[pum_pkg::USB_LSB +: 2]);
    end
    // An event sets the status only for a supported state; set wins.
    if (wake_evt && st_r.sup[sup_idx]) begin // (R08)
      st_nxt.wake_st = 1'b1;
    end
    // The power reset edge in D3 touches the power state only.
    if (d0_force) begin // (R14)
      st_nxt.pstate = pum_pkg::PS_D0;
    end
    // A power reset outside D3 clears everything.
    if (clr) begin // (R15)
      st_nxt.pstate = pum_pkg::PS_D0; // (R22)
      st_nxt.wake_en = 1'b0;
      st_nxt.wake_st = 1'b0;
      st_nxt.sup = pum_pkg::SUP_RST;
      st_nxt.aux = pum_pkg::AUX_RST;
      st_nxt.usb_req = pum_pkg::pum_usb_reset;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.pstate <= pum_pkg::PS_D0; // (R22)
      st_r.wake_en <= 1'b0;
      st_r.wake_st <= 1'b0;
      st_r.sup <= pum_pkg::SUP_RST;
      st_r.aux <= pum_pkg::AUX_RST;
      st_r.usb_req <= pum_pkg::pum_usb_reset;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Read views and derived outputs.
  always_comb begin
    pmcsr_rd = '0;
    pmcsr_rd[pum_pkg::PS_LSB +: 2] = st_r.pstate;
    pmcsr_rd[pum_pkg::WEN_BIT] = st_r.wake_en;
    pmcsr_rd[pum_pkg::WST_BIT] = st_r.wake_st;
    pmc_rd = '0;
    pmc_rd[pum_pkg::SUP_LSB +: pum_pkg::SUP_W] = st_r.sup;
    pmc_rd[pum_pkg::AUX_LSB +: pum_pkg::AUX_W] = st_r.aux;
    // Outside D0 the bus may only sit in reset or suspend.
    usb_eff = st_r.usb_req;
    if (st_r.pstate != pum_pkg::PS_D0 &&
        (st_r.usb_req == pum_pkg::pum_usb_oper ||
         st_r.usb_req == pum_pkg::pum_usb_resume)) begin // (R05)
      usb_eff = pum_pkg::pum_usb_susp;
    end
    usb_rd = '0;
    usb_rd[pum_pkg::USB_LSB +: 2] = st_r.usb_req;
    usb_rd[pum_pkg::USBEFF_LSB +: 2] = usb_eff;
    wake_req = st_r.wake_st & st_r.wake_en; // (R21)
    in_d3 = (st_r.pstate == pum_pkg::PS_D3);
  end

endmodule

// >>> hw/pum_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs; only the second stage is seen.
module pum_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous level and its synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read by the second stage only.
  logic [W-1:0] meta_r;

  // Both stages reset to zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// >>> hw/pum_top.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// (R01) D0 with B0: any bus transaction allowed.
// (R02) D1 in B1: wake events only.
// (R03) D2/D3hot in B1 or B2: wake only.
// (R04) D3cold in B3: reset or wake only.
// (R05) Outside D0 USB held in reset or suspend.
// (R06) USB states: reset, active, J, K.
// (R07) Software writes all cores identically.
// (R08) Wake status set only in supported states.
// (R09) Software sets D3cold bit and aux current.
// (R10) Capabilities writable under override or ROM load.
// (R11) Firmware restores capabilities after power-off.
// (R12) Software sets state and enable before S3.
// (R13) Wake output independent of the bus clock.
// (R14) Power reset rise in D3 returns D0.
// (R15) Power reset outside D3 clears everything.
// (R16) Bus signals disabled while power reset low.
// (R17) System holds power reset high normally.
// (R18) Power reset rises after bus reset release.
// (R19) Without cold wake, power reset tied high.
// (R20) Host stops bus clock in B2; reset gives B0.
// (R21) Wake output ORs enabled core wake flags.
// (R22) After reset: D0, wake bits cleared.
module pum_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [pum_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pum_pkg::DATA_W-1:0] pwdata,
  output logic [pum_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the system.
  input wire logic core_power_reset_in,
  input wire logic [1:0] pci_bus_state_in,
  input wire logic [pum_pkg::NCORE-1:0] usb_wake_in,
  // Capability load from the serial ROM loader.
  input wire logic rom_load_valid,
  input wire logic [pum_pkg::SUP_W-1:0] rom_sup,
  input wire logic [pum_pkg::AUX_W-1:0] rom_aux,
  // Outputs towards the bus and the USB side.
  output logic wake_event_out,
  output logic pci_bus_enable,
  output logic pci_txn_allow,
  output logic pci_wake_only,
  output logic [2*pum_pkg::NCORE-1:0] usb_state_out
);

  localparam int N = pum_pkg::NCORE;

  // Synchronised copies of the pins.
  logic crst_s;
  logic [1:0] bus_s;
  logic [N-1:0] wake_s;

  // Registered state of the top level.
  typedef struct packed {
    logic crst_q;
    logic [N-1:0] wake_q;
    logic id_ovr;
    logic bus_err;
    logic pready;
    logic pslverr;
    logic [pum_pkg::DATA_W-1:0] prdata;
    logic wake_out;
    logic bus_en;
    logic txn_allow;
    logic wake_only;
    logic [2*N-1:0] usb;
  } pum_top_st_t;

  pum_top_st_t st_r;
  pum_top_st_t st_nxt;

  // Per-core wiring.
  logic [N-1:0] wr_pmcsr;
  logic [N-1:0] wr_pmc;
  logic [N-1:0] wr_usb;
  logic [N-1:0] wake_evt;
  logic [N-1:0] wake_req;
  logic [N-1:0] in_d3;
  logic [31:0] pmcsr_rd [N];
  logic [31:0] pmc_rd [N];
  logic [31:0] usb_rd [N];
  pum_pkg::pum_usb_t usb_eff [N];

  // Derived controls.
  logic any_d3;
  logic soft_clr;
  logic d0_force;
  logic cold;
  logic wr_fire;
  logic [31:0] rd_mux;
  logic rd_hit;

  // Checks the core count against the address map.
  // Only three core windows fit below the global registers.
  initial begin
    if (N < 1 || N > 3) begin
      $error("core count does not fit the register map");
    end
  end

  // Core window number of an address, N when none matches.
  function automatic int core_of(logic [pum_pkg::ADDR_W-1:0] a);
    int r;
    r = N;
    for (int i = 0; i < N; i++) begin
      if (a[7:4] == 4'(i)) begin
        r = i;
      end
    end
    return r;
  endfunction

  // Offset of an address inside its core window.
  function automatic logic [7:0] win_ofs(
      logic [pum_pkg::ADDR_W-1:0] a);
    return a & (pum_pkg::CORE_STRIDE - 8'h01);
  endfunction

  // Power state field of a status read view.
  function automatic logic [1:0] ps_of(logic [31:0] w);
    return w[pum_pkg::PS_LSB +: 2];
  endfunction

  // Pin synchronisers.
  pum_sync #(.W(1)) u_sync_crst (
    .clk(pclk),
    .rst_n(presetn),
    .d(core_power_reset_in),
    .q(crst_s)
  );

  // The bus state pins come from the system power logic.
  // Both bits cross as one word, so a move between codes that differ
  // in two bits may show a middle code for one cycle; the mismatch
  // flag may then record a false state, which software must tolerate.
  pum_sync #(.W(2)) u_sync_bus (
    .clk(pclk),
    .rst_n(presetn),
    .d(pci_bus_state_in),
    .q(bus_s)
  );

  // USB-side wake detections, one per core.
  pum_sync #(.W(N)) u_sync_wake (
    .clk(pclk),
    .rst_n(presetn),
    .d(usb_wake_in),
    .q(wake_s)
  );

  // A wake detection counts once, on its rising edge.
  // A pin that stays high cannot set the flag again after a clear.
  assign wake_evt = wake_s & ~st_r.wake_q;

  // Bus power gone while the function sits in D3 is D3cold.
  assign cold = (bus_s == pum_pkg::BUS_B3);

  // Any core in D3; software keeps the cores equal.
  assign any_d3 = |in_d3; // (R07)

  // Low power reset outside D3 clears the whole block.
  assign soft_clr = !crst_s && !any_d3; // (R15)

  // Rising power reset while in D3 returns the power state only.
  // The rest stays intact, so a wake seen in D3cold survives it.
  assign d0_force = crst_s && !st_r.crst_q && any_d3; // (R14)

  // A write takes effect at the access edge, bus enabled only.
  // Writes while the bus is disabled are dropped, not delayed.
  assign wr_fire = psel && penable && st_r.pready && pwrite &&
                   crst_s; // (R16)

  // Per-core slices.
  generate
    for (genvar g = 0; g < N; g++) begin : g_core
      // Write strobes for this core's window.
      assign wr_pmcsr[g] = wr_fire && core_of(paddr) == g &&
                           win_ofs(paddr) == pum_pkg::OFS_PMCSR;
      assign wr_pmc[g] = wr_fire && core_of(paddr) == g &&
                         win_ofs(paddr) == pum_pkg::OFS_PMC;
      assign wr_usb[g] = wr_fire && core_of(paddr) == g &&
                         win_ofs(paddr) == pum_pkg::OFS_USB;

      // One slice keeps the registers of one core.
      pum_core_pm u_core (
        .clk(pclk),
        .rst_n(presetn),
        .clr(soft_clr),
        .d0_force(d0_force),
        .wr_pmcsr(wr_pmcsr[g]),
        .wr_pmc(wr_pmc[g]),
        .wr_usb(wr_usb[g]),
        .wdata(pwdata),
        .id_ovr(st_r.id_ovr),
        .rom_valid(rom_load_valid),
        .rom_sup(rom_sup),
        .rom_aux(rom_aux),
        .wake_evt(wake_evt[g]),
        .cold(cold),
        .pmcsr_rd(pmcsr_rd[g]),
        .pmc_rd(pmc_rd[g]),
        .usb_rd(usb_rd[g]),
        .wake_req(wake_req[g]),
        .in_d3(in_d3[g]),
        .usb_eff(usb_eff[g])
      );
    end
  endgenerate

  // Read data selection; unmapped addresses flag an error.
  always_comb begin
    int c;
    logic [7:0] o;
    c = core_of(paddr);
    o = win_ofs(paddr);
    rd_mux = '0;
    rd_hit = 1'b1;
    if (paddr == pum_pkg::OFS_GCTRL) begin
      rd_mux[pum_pkg::IDOVR_BIT] = st_r.id_ovr;
    end else if (paddr == pum_pkg::OFS_GSTAT) begin
      rd_mux[pum_pkg::BUSERR_BIT] = st_r.bus_err;
      rd_mux[pum_pkg::BUS_LSB +: 2] = bus_s;
      rd_mux[pum_pkg::CRST_BIT] = crst_s;
    end else if (c < N && o == pum_pkg::OFS_PMCSR) begin
      rd_mux = pmcsr_rd[c];
    end else if (c < N && o == pum_pkg::OFS_PMC) begin
      rd_mux = pmc_rd[c];
    end else if (c < N && o == pum_pkg::OFS_USB) begin
      rd_mux = usb_rd[c];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Next state of the top level.
  always_comb begin
    logic illegal;
    st_nxt = st_r;
    illegal = 1'b0;
    st_nxt.crst_q = crst_s;
    st_nxt.wake_q = wake_s;

    // APB: one wait-free access cycle after every setup cycle.
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
      // Accesses while the power reset is low are refused.
      st_nxt.pslverr = !rd_hit || !crst_s; // (R16)
      st_nxt.prdata = (crst_s && !pwrite) ? rd_mux : '0;
    end

    // Identifier override bit.
    if (wr_fire && paddr == pum_pkg::OFS_GCTRL) begin
      st_nxt.id_ovr = pwdata[pum_pkg::IDOVR_BIT];
    end

    // Function state against bus state.
    for (int i = 0; i < N; i++) begin
      // D0 needs B0; D1 allows B0 or B1 only.
      if (!in_d3[i] && ps_of(pmcsr_rd[i]) == pum_pkg::PS_D0 &&
          bus_s != pum_pkg::BUS_B0) begin // (R01)
        illegal = 1'b1;
      end
      if (ps_of(pmcsr_rd[i]) == pum_pkg::PS_D1 &&
          (bus_s == pum_pkg::BUS_B2 ||
           bus_s == pum_pkg::BUS_B3)) begin // (R02)
        illegal = 1'b1;
      end
      // D2 may not lose bus power; only D3 may see B3.
      if (ps_of(pmcsr_rd[i]) == pum_pkg::PS_D2 &&
          bus_s == pum_pkg::BUS_B3) begin // (R03)
        illegal = 1'b1;
      end
    end
    // Sticky mismatch flag; a new mismatch wins over the clear.
    if (wr_fire && paddr == pum_pkg::OFS_GSTAT &&
        pwdata[pum_pkg::BUSERR_BIT]) begin
      st_nxt.bus_err = 1'b0;
    end
    if (illegal) begin
      st_nxt.bus_err = 1'b1;
    end

    // Transactions only in B0 with the bus enabled; wake only outside B0.
    st_nxt.bus_en = crst_s; // (R16)
    st_nxt.txn_allow = crst_s &&
                       bus_s == pum_pkg::BUS_B0; // (R01)
    st_nxt.wake_only = bus_s != pum_pkg::BUS_B0; // (R03)
    if (cold) begin
      st_nxt.txn_allow = 1'b0; // (R04)
    end

    // Wake output from enabled flags, no bus clock involved.
    st_nxt.wake_out = |wake_req; // (R21)
    // USB bus state per core, two bits each.
    for (int i = 0; i < N; i++) begin
      st_nxt.usb[2*i +: 2] = usb_eff[i]; // (R06)
    end

    // Full clear on a power reset outside D3.
    if (soft_clr) begin // (R15)
      st_nxt.id_ovr = 1'b0;
      st_nxt.bus_err = 1'b0;
      st_nxt.wake_out = 1'b0;
    end
  end

  // State register; reset leaves the bus fully disabled.
  // Every field resets to zero, which is D0, idle and no wake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0; // (R22)
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  // No gate follows the flops, so the system pins never glitch.
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  // The wake path runs on the always-on core clock.
  assign wake_event_out = st_r.wake_out; // (R13)
  assign pci_bus_enable = st_r.bus_en;
  assign pci_txn_allow = st_r.txn_allow;
  assign pci_wake_only = st_r.wake_only;
  assign usb_state_out = st_r.usb;

endmodule
